// ---- inc/bsc_regs_cfg.svh ----
// register offsets, field positions, reset values and clock rates for the board status/control bank
// assumes byte addresses on a 32-bit register port, one aligned word per register
`ifndef BSC_REGS_CFG_SVH
`define BSC_REGS_CFG_SVH

`define BSC_ADDR_W 32
`define BSC_OFF_CARD_SOCKET 32'h10000048
`define BSC_OFF_STATIC_MEM 32'h1000004C
`define BSC_OFF_DISPLAY 32'h10000050
`define BSC_OFF_CFG_SWITCH 32'h10000058
`define BSC_OFF_FAST_COUNTER 32'h1000005C
`define BSC_OFF_MISC 32'h10000060
`define BSC_OFF_IRQ_STATUS 32'h10000070
`define BSC_OFF_IRQ_MASK 32'h10000078

`define BSC_BIT_CARD_PRESENT 0
`define BSC_BIT_CARD_WP 1
`define BSC_BIT_STATIC_WE 0
`define BSC_BIT_SERIAL_SEL 7
`define BSC_LSB_DISPLAY_ID 8
`define BSC_MSB_DISPLAY_ID 12
`define BSC_BIT_SW_IRQ 19
`define BSC_BIT_SERIAL_SRC 18
`define BSC_BIT_VIDEO_SRC 17
`define BSC_BIT_COMPACT_ABSENT 16
`define BSC_BIT_TILE_ABSENT 13

`define BSC_RST_DISPLAY_ID 5'h1F
`define BSC_RST_COMPACT_ABSENT 1'h1
`define BSC_RST_TILE_ABSENT 1'h0
`define BSC_CFG_SWITCH_W 8
`define BSC_EVT_W 4

// reference crystal rate and system clock rate, in kHz
`define BSC_REF_KHZ 24000
`define BSC_SYS_KHZ 125000

`endif

// ---- inc/bsc_pkg.sv ----
// types shared by the board status/control bank
// assumes bsc_regs_cfg.svh holds all numeric constants
package bsc_pkg;
    typedef enum logic [2:0] {
        BSC_SEL_NONE = 3'b000,
        BSC_SEL_CARD = 3'b001,
        BSC_SEL_STATIC = 3'b010,
        BSC_SEL_DISPLAY = 3'b011,
        BSC_SEL_SWITCH = 3'b100,
        BSC_SEL_COUNTER = 3'b101,
        BSC_SEL_MISC = 3'b110,
        BSC_SEL_IRQ = 3'b111
    } bsc_sel_t;
endpackage

// ---- rtl/bsc_sync2.sv ----
// two-flop synchroniser for a bus of asynchronous inputs
// assumes the inputs are quasi-static levels from pins
`timescale 1ns/1ps
module bsc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- rtl/bsc_regs.sv ----
// board status/control register bank on a plain strobe register port
// assumes pins are asynchronous and the 24 MHz reference arrives as a pin sampled on sys_clk
`timescale 1ns/1ps
`include "bsc_regs_cfg.svh"

// Function
// - the card socket, static memory and display registers sit at their fixed system addresses.
// - card socket bit 0 is read-only card presence, 1 meaning a card is detected, reset 0.
// - card socket bit 1 is read-only write-protect state of the card, reset 0.
// - static memory bit 0 is read/write flash write enable, cleared by reset.
// - undefined bits ignore writes and read zero.
// - display bits 12 to 8 read the five adaptor id links, reset all ones.
// - display bit 7 is read/write, reset 0, and drives the external serial chip select active when 1.
// - the switch register is read-only and shows a 1 for each switch that is on.
// - the counter register is a read-only 32-bit count stepping once per reference clock cycle.
// - reset clears the counter, which then counts up from zero.
// - misc bit 18 is read/write, reset 0, selecting baseboard or tile site for serial ports three and four.
// - misc bit 17 is read/write, reset 0, selecting baseboard or tile site for the video connector.
// - misc bit 16 is read-only active-low compact card detect, reset 1.
// - misc bit 13 is read-only active-low tile detect.
module bsc_regs
    import bsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic card_present,
    input wire logic card_write_protect,
    input wire logic [4:0] display_adaptor_id,
    input wire logic [`BSC_CFG_SWITCH_W-1:0] config_switch,
    input wire logic crystal_ref_clock,
    input wire logic compact_card_absent,
    input wire logic tile_absent,
    output logic static_mem_write_enable,
    output logic ext_serial_chip_select_n,
    output logic serial_src_tile,
    output logic video_src_tile,
    output logic software_irq_flag,
    output logic irq
);
    function automatic bsc_sel_t decode(input logic [31:0] addr);
        case (addr)
            `BSC_OFF_CARD_SOCKET: decode = BSC_SEL_CARD;
            `BSC_OFF_STATIC_MEM: decode = BSC_SEL_STATIC;
            `BSC_OFF_DISPLAY: decode = BSC_SEL_DISPLAY;
            `BSC_OFF_CFG_SWITCH: decode = BSC_SEL_SWITCH;
            `BSC_OFF_FAST_COUNTER: decode = BSC_SEL_COUNTER;
            `BSC_OFF_MISC: decode = BSC_SEL_MISC;
            `BSC_OFF_IRQ_STATUS: decode = BSC_SEL_IRQ;
            `BSC_OFF_IRQ_MASK: decode = BSC_SEL_IRQ;
            default: decode = BSC_SEL_NONE;
        endcase
    endfunction

    // synchronised pin states
    logic s_card_present;
    logic s_card_wp;
    logic [4:0] s_display_id;
    logic [`BSC_CFG_SWITCH_W-1:0] s_switch;
    logic s_refclk;
    logic s_compact_absent;
    logic s_tile_absent;

    bsc_sync2 #(
        .WIDTH(`BSC_CFG_SWITCH_W + 10),
        .RESET_VAL({{`BSC_CFG_SWITCH_W{1'b0}}, 1'b0, 1'b0, `BSC_RST_DISPLAY_ID, 1'b0,
            `BSC_RST_COMPACT_ABSENT, `BSC_RST_TILE_ABSENT})
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in({config_switch, card_present, card_write_protect, display_adaptor_id, crystal_ref_clock,
            compact_card_absent, tile_absent}),
        .sync_out({s_switch, s_card_present, s_card_wp, s_display_id, s_refclk, s_compact_absent,
            s_tile_absent})
    );

    // control state
    logic static_we;
    logic serial_sel;
    logic serial_src;
    logic video_src;
    logic sw_irq;
    logic [31:0] fast_count;
    logic ref_prev;
    logic ref_rise;
    logic [`BSC_EVT_W-1:0] irq_status;
    logic [`BSC_EVT_W-1:0] irq_mask;
    logic [`BSC_EVT_W-1:0] events;
    logic card_prev;
    logic tile_prev;
    logic compact_prev;

    bsc_sel_t wr_sel;
    bsc_sel_t rd_sel;
    logic [31:0] next_rdata;

    assign wr_sel = reg_wr ? decode(reg_addr) : BSC_SEL_NONE;
    assign rd_sel = reg_rd ? decode(reg_addr) : BSC_SEL_NONE;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            static_we <= 1'b0;
        end else if (wr_sel == BSC_SEL_STATIC) begin
            static_we <= reg_wdata[`BSC_BIT_STATIC_WE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            serial_sel <= 1'b0;
        end else if (wr_sel == BSC_SEL_DISPLAY) begin
            serial_sel <= reg_wdata[`BSC_BIT_SERIAL_SEL];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            serial_src <= 1'b0;
            video_src <= 1'b0;
            sw_irq <= 1'b0;
        end else if (wr_sel == BSC_SEL_MISC) begin
            serial_src <= reg_wdata[`BSC_BIT_SERIAL_SRC];
            video_src <= reg_wdata[`BSC_BIT_VIDEO_SRC];
            sw_irq <= reg_wdata[`BSC_BIT_SW_IRQ];
        end
    end

    // reference clock edges detected from the synchronised copy; the 24 MHz rate
    // is below half of sys_clk so no edge is missed
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= s_refclk;
        end
    end
    assign ref_rise = s_refclk & ~ref_prev;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fast_count <= 32'h0;
        end else if (ref_rise) begin
            fast_count <= fast_count + 32'h1;
        end
    end

    // status change events: card insert/remove, tile change, compact card change; bit 3 never set
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            card_prev <= 1'b0;
            tile_prev <= `BSC_RST_TILE_ABSENT;
            compact_prev <= `BSC_RST_COMPACT_ABSENT;
        end else begin
            card_prev <= s_card_present;
            tile_prev <= s_tile_absent;
            compact_prev <= s_compact_absent;
        end
    end
    // bit 3 stays clear: the software flag reaches irq directly through mask bit 3
    assign events = {1'b0,
        compact_prev ^ s_compact_absent, tile_prev ^ s_tile_absent, card_prev ^ s_card_present};

    // status clears on a read of it; an event in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_status <= '0;
        end else if (rd_sel == BSC_SEL_IRQ && reg_addr == `BSC_OFF_IRQ_STATUS) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_mask <= '0;
        end else if (wr_sel == BSC_SEL_IRQ && reg_addr == `BSC_OFF_IRQ_MASK) begin
            irq_mask <= reg_wdata[`BSC_EVT_W-1:0];
        end
    end

    // read mux; undefined bits stay zero
    always_comb begin
        next_rdata = 32'h0;
        case (rd_sel)
            BSC_SEL_CARD: begin
                next_rdata[`BSC_BIT_CARD_PRESENT] = s_card_present;
                next_rdata[`BSC_BIT_CARD_WP] = s_card_wp;
            end
            BSC_SEL_STATIC: next_rdata[`BSC_BIT_STATIC_WE] = static_we;
            BSC_SEL_DISPLAY: begin
                next_rdata[`BSC_MSB_DISPLAY_ID:`BSC_LSB_DISPLAY_ID] = s_display_id;
                next_rdata[`BSC_BIT_SERIAL_SEL] = serial_sel;
            end
            BSC_SEL_SWITCH: next_rdata[`BSC_CFG_SWITCH_W-1:0] = s_switch;
            BSC_SEL_COUNTER: next_rdata = fast_count;
            BSC_SEL_MISC: begin
                next_rdata[`BSC_BIT_SW_IRQ] = sw_irq;
                next_rdata[`BSC_BIT_SERIAL_SRC] = serial_src;
                next_rdata[`BSC_BIT_VIDEO_SRC] = video_src;
                next_rdata[`BSC_BIT_COMPACT_ABSENT] = s_compact_absent;
                next_rdata[`BSC_BIT_TILE_ABSENT] = s_tile_absent;
            end
            BSC_SEL_IRQ: begin
                if (reg_addr == `BSC_OFF_IRQ_STATUS) begin
                    next_rdata[`BSC_EVT_W-1:0] = irq_status;
                end else begin
                    next_rdata[`BSC_EVT_W-1:0] = irq_mask;
                end
            end
            BSC_SEL_NONE: next_rdata = 32'h0;
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign static_mem_write_enable = static_we;
    assign ext_serial_chip_select_n = ~serial_sel;
    assign serial_src_tile = serial_src;
    assign video_src_tile = video_src;
    assign software_irq_flag = sw_irq;
    assign irq = |(irq_status & irq_mask) | (sw_irq & irq_mask[`BSC_EVT_W-1]);

    // assertions
    sequence misc_write_s;
        reg_wr && reg_addr == `BSC_OFF_MISC;
    endsequence

    serial_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_wr && reg_addr == `BSC_OFF_DISPLAY |=> ext_serial_chip_select_n == !$past(reg_wdata[7]))
        else $error("serial select does not follow write");
    flash_enable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_wr && reg_addr == `BSC_OFF_STATIC_MEM |=> static_mem_write_enable == $past(reg_wdata[0]))
        else $error("flash enable not written");
    soft_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        misc_write_s |=> software_irq_flag == $past(reg_wdata[19]))
        else $error("software irq flag not written");
    misc_selects_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        misc_write_s |=> serial_src_tile == $past(reg_wdata[18]) && video_src_tile == $past(reg_wdata[17]))
        else $error("misc selects not written");
    counter_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ref_rise |=> fast_count == $past(fast_count) + 32'h1)
        else $error("counter did not step on reference edge");
    counter_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ref_rise |=> $stable(fast_count))
        else $error("counter moved without reference edge");
    counter_reset_a: assert property (@(posedge sys_clk)
        !resetn |=> fast_count == 32'h0)
        else $error("counter not cleared by reset");
    card_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd && reg_addr == `BSC_OFF_CARD_SOCKET |=> reg_rdata[31:2] == 30'h0)
        else $error("undefined card socket bits not zero");
    misc_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd && reg_addr == `BSC_OFF_MISC |=> reg_rdata[16] == $past(s_compact_absent)
        && reg_rdata[13] == $past(s_tile_absent) && reg_rdata[15:14] == 2'h0)
        else $error("misc read value wrong");
    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd && decode(reg_addr) == BSC_SEL_NONE |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    display_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd && reg_addr == `BSC_OFF_DISPLAY |=> reg_rdata[12:8] == $past(s_display_id)
        && reg_rdata[6:0] == 7'h0)
        else $error("display id read wrong");
endmodule

// ---- tb/board_status_control_regs_tb_top.sv ----
// self-checking bench for the board status/control register bank
// assumes bsc_regs on a one-cycle strobe register port, pins quasi-static, no reference between frames
`timescale 1ns/1ps
`include "bsc_regs_cfg.svh"
module board_status_control_regs_tb_top
    import bsc_pkg::*;
();
    logic sys_clk;
    logic resetn;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic card_present;
    logic card_write_protect;
    logic [4:0] display_adaptor_id;
    logic [`BSC_CFG_SWITCH_W-1:0] config_switch;
    logic crystal_ref_clock;
    logic compact_card_absent;
    logic tile_absent;
    logic static_mem_write_enable;
    logic ext_serial_chip_select_n;
    logic serial_src_tile;
    logic video_src_tile;
    logic software_irq_flag;
    logic irq;
    logic [31:0] rd_val;
    logic [31:0] first_cnt;
    int error_cnt;
    int checks;

    bsc_regs dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_present(card_present),
        .card_write_protect(card_write_protect), .display_adaptor_id(display_adaptor_id),
        .config_switch(config_switch), .crystal_ref_clock(crystal_ref_clock),
        .compact_card_absent(compact_card_absent), .tile_absent(tile_absent),
        .static_mem_write_enable(static_mem_write_enable), .ext_serial_chip_select_n(ext_serial_chip_select_n),
        .serial_src_tile(serial_src_tile), .video_src_tile(video_src_tile),
        .software_irq_flag(software_irq_flag), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task automatic read_check(input logic [31:0] addr, input logic [31:0] exp);
        bus_read(addr, rd_val);
        check_word(rd_val, exp);
    endtask

    // two sync flops plus margin
    task automatic settle();
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
    endtask

    // six sys_clk cycles per reference period keeps it below half the bus clock
    task automatic ref_pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge sys_clk);
            crystal_ref_clock <= 1'b1;
            repeat (3) @(posedge sys_clk);
            crystal_ref_clock <= 1'b0;
        end
    endtask

    task automatic test_reset_state();
        #1;
        check_bit(static_mem_write_enable, 1'b0);
        check_bit(ext_serial_chip_select_n, 1'b1);
        check_bit(serial_src_tile, 1'b0);
        check_bit(video_src_tile, 1'b0);
        check_bit(software_irq_flag, 1'b0);
        check_bit(irq, 1'b0);
        read_check(`BSC_OFF_CARD_SOCKET, 32'h00000000);
        read_check(`BSC_OFF_STATIC_MEM, 32'h00000000);
        read_check(`BSC_OFF_DISPLAY, 32'h00001F00);
        read_check(`BSC_OFF_MISC, 32'h00010000);
        read_check(`BSC_OFF_FAST_COUNTER, 32'h00000000);
        $display("test reset_state done");
    endtask

    task automatic test_rw_regs();
        bus_write(`BSC_OFF_STATIC_MEM, 32'hFFFFFFFF);
        bus_write(`BSC_OFF_DISPLAY, 32'hFFFFFFFF);
        bus_write(`BSC_OFF_MISC, 32'hFFFFFFFF);
        check_bit(static_mem_write_enable, 1'b1);
        check_bit(ext_serial_chip_select_n, 1'b0);
        check_bit(serial_src_tile, 1'b1);
        check_bit(video_src_tile, 1'b1);
        check_bit(software_irq_flag, 1'b1);
        check_bit(irq, 1'b0);
        read_check(`BSC_OFF_STATIC_MEM, 32'h00000001);
        read_check(`BSC_OFF_DISPLAY, 32'h00001F80);
        read_check(`BSC_OFF_MISC, 32'h000F0000);
        bus_write(`BSC_OFF_CARD_SOCKET, 32'hFFFFFFFF);
        bus_write(`BSC_OFF_CFG_SWITCH, 32'hFFFFFFFF);
        read_check(`BSC_OFF_CARD_SOCKET, 32'h00000000);
        read_check(`BSC_OFF_CFG_SWITCH, 32'h00000000);
        bus_write(`BSC_OFF_DISPLAY, 32'h00000000);
        bus_write(`BSC_OFF_MISC, 32'h00000000);
        check_bit(ext_serial_chip_select_n, 1'b1);
        check_bit(serial_src_tile, 1'b0);
        check_bit(video_src_tile, 1'b0);
        check_bit(software_irq_flag, 1'b0);
        read_check(`BSC_OFF_MISC, 32'h00010000);
        $display("test rw_regs done");
    endtask

    task automatic test_pins();
        @(posedge sys_clk);
        card_present <= 1'b1;
        card_write_protect <= 1'b1;
        display_adaptor_id <= 5'h0A;
        config_switch <= 8'hA5;
        compact_card_absent <= 1'b0;
        tile_absent <= 1'b1;
        settle();
        read_check(`BSC_OFF_CARD_SOCKET, 32'h00000003);
        read_check(`BSC_OFF_DISPLAY, 32'h00000A00);
        read_check(`BSC_OFF_CFG_SWITCH, 32'h000000A5);
        read_check(`BSC_OFF_MISC, 32'h00002000);
        $display("test pins done");
    endtask

    task automatic test_unmapped();
        bus_write(32'h10000054, 32'hFFFFFFFF);
        read_check(32'h10000054, 32'h00000000);
        read_check(32'h10000064, 32'h00000000);
        read_check(`BSC_OFF_STATIC_MEM, 32'h00000001);
        $display("test unmapped done");
    endtask

    task automatic test_irq();
        bus_read(`BSC_OFF_IRQ_STATUS, rd_val);
        bus_write(`BSC_OFF_IRQ_MASK, 32'h00000000);
        @(posedge sys_clk);
        card_present <= ~card_present;
        tile_absent <= ~tile_absent;
        compact_card_absent <= ~compact_card_absent;
        settle();
        check_bit(irq, 1'b0);
        read_check(`BSC_OFF_IRQ_STATUS, 32'h00000007);
        read_check(`BSC_OFF_IRQ_STATUS, 32'h00000000);
        bus_write(`BSC_OFF_IRQ_MASK, 32'h00000001);
        card_present <= ~card_present;
        settle();
        check_bit(irq, 1'b1);
        read_check(`BSC_OFF_IRQ_STATUS, 32'h00000001);
        check_bit(irq, 1'b0);
        bus_write(`BSC_OFF_IRQ_MASK, 32'h00000008);
        bus_write(`BSC_OFF_MISC, 32'h00080000);
        check_bit(irq, 1'b1);
        bus_write(`BSC_OFF_IRQ_MASK, 32'h00000000);
        check_bit(irq, 1'b0);
        check_bit(software_irq_flag, 1'b1);
        bus_write(`BSC_OFF_MISC, 32'h00000000);
        check_bit(software_irq_flag, 1'b0);
        $display("test irq done");
    endtask

    task automatic test_counter();
        bus_read(`BSC_OFF_FAST_COUNTER, first_cnt);
        ref_pulses(10);
        settle();
        bus_read(`BSC_OFF_FAST_COUNTER, rd_val);
        check_word(rd_val - first_cnt, 32'h0000000A);
        bus_write(`BSC_OFF_STATIC_MEM, 32'h00000001);
        do_reset();
        #1;
        check_bit(static_mem_write_enable, 1'b0);
        read_check(`BSC_OFF_FAST_COUNTER, 32'h00000000);
        ref_pulses(3);
        settle();
        read_check(`BSC_OFF_FAST_COUNTER, 32'h00000003);
        $display("test counter done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end

    initial begin
        error_cnt = 0;
        checks = 0;
        resetn = 1'b0;
        reg_addr = 32'h00000000;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        card_present = 1'b0;
        card_write_protect = 1'b0;
        display_adaptor_id = 5'h1F;
        config_switch = 8'h00;
        crystal_ref_clock = 1'b0;
        compact_card_absent = 1'b1;
        tile_absent = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        test_reset_state();
        test_rw_regs();
        test_pins();
        test_unmapped();
        test_irq();
        test_counter();
        report_and_stop();
    end
endmodule
